// *** das_pkg.sv ***
// shared constants and types for the dual converter scan sequencer
package das_pkg;
  localparam int CLK_MHZ = 40;
  localparam int SAMPLE_NS = 20000;
  localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int WARM_NS = 10000;
  localparam int WARM_CYC = (WARM_NS * CLK_MHZ + 999) / 1000;
  localparam int NUM_CONV = 2;
  localparam int NUM_MON = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] BATT_CHAN = 4'h8;
  localparam logic [3:0] NO_CHAN = 4'hf;
  localparam logic [8:0] EXT_MASK = 9'h0ff;
  localparam int TAG_LSB = 12;
  localparam int IRQ_SAMPLE = 0;
  localparam int IRQ_SEQ = 1;
  localparam int IRQ_FIFO = 2;

  typedef struct packed {
    logic en;
    logic [8:0] active;
    logic [31:0] delay;
  } das_conv_cfg_type;

  typedef struct packed {
    logic en;
    logic gt;
    logic [3:0] chan;
    logic [11:0] limit;
  } das_mon_type;

  typedef enum logic [2:0] {
    DAS_IDLE, DAS_SETTLE, DAS_CONVERT, DAS_STORE
  } das_state_type;
endpackage : das_pkg

// *** das_sequencer.sv ***
// two converter scan sequencers, threshold monitors and shared sample fifo
`timescale 1ns/100ps
// Contract
// - two 12-bit converters, any input either
// - first converter adds battery channel eight
// - 8-bit prescaler clocks timer and sequencer; only the timers use it, scan steps run on sys_clk
// - private timer and sequencer per converter
// - scan samples every active channel enabled
// - monitors: enable, channel, less or greater
// - battery has own upper and lower limits
// - all monitors can raise interrupt
// - warm-up, separate conversion clock divider
// - shared 8x16 fifo with channel tag
// - fifo read through one data port
// - enableable sample, sequencer, fifo interrupts
// - software command samples immediately
// - sample time never under 20 us
module das_sequencer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] prescale,
  input wire logic [7:0] conv_div,
  input das_pkg::das_conv_cfg_type conv_cfg [das_pkg::NUM_CONV],
  input wire logic [1:0] cmd_sample,
  input das_pkg::das_mon_type mon_cfg [das_pkg::NUM_MON],
  input wire logic [11:0] batt_high,
  input wire logic [11:0] batt_low,
  input wire logic [1:0] conv_done,
  input wire logic [11:0] conv_result [das_pkg::NUM_CONV],
  input wire logic fifo_read,
  input wire logic [3:0] fifo_level,
  input wire logic [2:0] irq_enable,
  input wire logic [7:0] mon_clear,
  input wire logic [1:0] batt_clear,
  input wire logic [1:0] seq_clear,
  output logic [3:0] mux_sel [das_pkg::NUM_CONV],
  output logic [1:0] conv_start,
  output logic conv_clk,
  output logic analog_on,
  output logic warm,
  output logic [15:0] fifo_data,
  output logic [3:0] fifo_count,
  output logic [7:0] mon_flag,
  output logic [1:0] batt_flag,
  output logic [1:0] seq_flag,
  output logic [1:0] busy,
  output logic irq
);
  // first active channel at or after start, none if mask exhausted
  function automatic logic [3:0] next_chan(input logic [8:0] mask,
                                            input logic [3:0] start);
    logic [3:0] found;
    found = das_pkg::NO_CHAN;
    for (int i = 8; i >= 0; i--) begin
      if (mask[i] && (4'(i) >= start)) begin
        found = 4'(i);
      end
    end
    return found;
  endfunction : next_chan

  function automatic logic [7:0] at_least_one(input logic [7:0] v);
    return (v == 8'h00) ? 8'h01 : v;
  endfunction : at_least_one

  // prescaled time base, shared tick for both timers
  logic [7:0] pre_cnt;
  logic tick;
  wire logic [7:0] pre_top = at_least_one(prescale) - 8'h01;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= (pre_cnt == pre_top);
      pre_cnt <= (pre_cnt >= pre_top) ? 8'h00 : pre_cnt + 8'h01;
    end
  end

  // conversion clock from its own divider, half period in clocks
  logic [7:0] div_cnt;
  wire logic [7:0] div_top = at_least_one(conv_div) - 8'h01;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
      conv_clk <= 1'b0;
    end else if (div_cnt >= div_top) begin
      div_cnt <= 8'h00;
      conv_clk <= ~conv_clk;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // warm-up: analog powered while any converter enabled
  logic [15:0] warm_cnt;
  wire logic any_en = conv_cfg[0].en | conv_cfg[1].en;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      warm_cnt <= 16'h0000;
      analog_on <= 1'b0;
      warm <= 1'b0;
    end else begin
      analog_on <= any_en;
      if (!any_en) begin
        warm_cnt <= 16'h0000;
        warm <= 1'b0;
      end else if (warm_cnt == 16'(das_pkg::WARM_CYC - 1)) begin
        warm <= 1'b1;
      end else begin
        warm_cnt <= warm_cnt + 16'h0001;
      end
    end
  end

  // fifo storage and write arbitration, converter 0 first
  logic [15:0] fifo_mem [das_pkg::FIFO_DEPTH];
  logic [2:0] wr_ptr;
  logic [2:0] rd_ptr;
  das_pkg::das_state_type state [das_pkg::NUM_CONV];
  logic [3:0] chan [das_pkg::NUM_CONV];
  logic [11:0] sample [das_pkg::NUM_CONV];
  wire logic fifo_full = (fifo_count == 4'(das_pkg::FIFO_DEPTH));
  wire logic fifo_empty = (fifo_count == 4'h0);
  wire logic [1:0] want;
  assign want[0] = (state[0] == das_pkg::DAS_STORE);
  assign want[1] = (state[1] == das_pkg::DAS_STORE);
  wire logic [1:0] grant;
  assign grant[0] = want[0] & ~fifo_full;
  assign grant[1] = want[1] & ~want[0] & ~fifo_full;
  wire logic wr_en = |grant;
  wire logic wr_sel = grant[1];
  wire logic [3:0] wr_chan = chan[wr_sel];
  wire logic [11:0] wr_val = sample[wr_sel];
  wire logic rd_en = fifo_read & ~fifo_empty;

  // per converter timer and scan state machine
  logic [31:0] timer [das_pkg::NUM_CONV];
  logic [15:0] settle [das_pkg::NUM_CONV];
  logic [1:0] scan_end;
  for (genvar c = 0; c < das_pkg::NUM_CONV; c++) begin : g_conv
    // second converter cannot see the battery channel
    wire logic [8:0] mask = (c == 0) ? conv_cfg[c].active
                          : (conv_cfg[c].active & das_pkg::EXT_MASK);
    wire logic [3:0] first = next_chan(mask, 4'h0);
    wire logic [3:0] after = (chan[c] == das_pkg::BATT_CHAN) ? das_pkg::NO_CHAN
                           : next_chan(mask, chan[c] + 4'h1);
    wire logic due = tick && (timer[c] == 32'h0000_0000);
    wire logic go = conv_cfg[c].en && warm && (cmd_sample[c] || due);
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        state[c] <= das_pkg::DAS_IDLE;
        timer[c] <= 32'h0000_0000;
        settle[c] <= 16'h0000;
        chan[c] <= 4'h0;
        sample[c] <= 12'h000;
        mux_sel[c] <= 4'h0;
        conv_start[c] <= 1'b0;
        scan_end[c] <= 1'b0;
        busy[c] <= 1'b0;
      end else begin
        conv_start[c] <= 1'b0;
        scan_end[c] <= 1'b0;
        unique case (state[c])
          das_pkg::DAS_IDLE: begin
            busy[c] <= 1'b0;
            // command overrides the timed schedule
            if (go && first != das_pkg::NO_CHAN) begin
              chan[c] <= first;
              mux_sel[c] <= first;
              settle[c] <= 16'h0000;
              timer[c] <= conv_cfg[c].delay;
              busy[c] <= 1'b1;
              state[c] <= das_pkg::DAS_SETTLE;
            end else if (tick) begin
              timer[c] <= (timer[c] == 32'h0000_0000) ? conv_cfg[c].delay
                        : timer[c] - 32'h0000_0001;
            end
          end
          das_pkg::DAS_SETTLE: begin
            // hold the input selected for the full sample time
            if (settle[c] == 16'(das_pkg::SAMPLE_CYC - 1)) begin
              conv_start[c] <= 1'b1;
              state[c] <= das_pkg::DAS_CONVERT;
            end else begin
              settle[c] <= settle[c] + 16'h0001;
            end
          end
          das_pkg::DAS_CONVERT: begin
            if (conv_done[c]) begin
              sample[c] <= conv_result[c];
              state[c] <= das_pkg::DAS_STORE;
            end
          end
          das_pkg::DAS_STORE: begin
            // a full fifo stalls the scan rather than dropping data
            if (grant[c]) begin
              if (after == das_pkg::NO_CHAN || !conv_cfg[c].en) begin
                scan_end[c] <= 1'b1;
                state[c] <= das_pkg::DAS_IDLE;
              end else begin
                chan[c] <= after;
                mux_sel[c] <= after;
                settle[c] <= 16'h0000;
                state[c] <= das_pkg::DAS_SETTLE;
              end
            end
          end
          default: state[c] <= das_pkg::DAS_IDLE;
        endcase
      end
    end
  end

  // strict compare, shared by general and battery monitors
  function automatic logic beyond(input logic [11:0] val,
                                  input logic [11:0] limit,
                                  input logic greater);
    return greater ? (val > limit) : (val < limit);
  endfunction : beyond

  // threshold comparison on the sample being stored
  logic [7:0] mon_hit;
  always_comb begin
    mon_hit = 8'h00;
    for (int m = 0; m < das_pkg::NUM_MON; m++) begin
      mon_hit[m] = wr_en && mon_cfg[m].en && (mon_cfg[m].chan == wr_chan)
                 && beyond(wr_val, mon_cfg[m].limit, mon_cfg[m].gt);
    end
  end

  // battery limits checked apart from the general monitors
  wire logic is_batt = wr_en && (wr_chan == das_pkg::BATT_CHAN);
  wire logic batt_over = is_batt && beyond(wr_val, batt_high, 1'b1);
  wire logic batt_under = is_batt && beyond(wr_val, batt_low, 1'b0);
  wire logic [1:0] batt_hit = {batt_over, batt_under};

  // interrupt sources, one enable bit each
  wire logic [7:0] level_top = at_least_one({4'h0, fifo_level});
  wire logic fifo_src = ({4'h0, fifo_count} >= level_top);
  wire logic seq_src = |seq_flag;
  wire logic sample_src = (|mon_flag) | (|batt_flag);
  wire logic [2:0] irq_src;
  assign irq_src[das_pkg::IRQ_SAMPLE] = sample_src;
  assign irq_src[das_pkg::IRQ_SEQ] = seq_src;
  assign irq_src[das_pkg::IRQ_FIFO] = fifo_src;

  // fifo pointers and occupancy; an empty read changes nothing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      fifo_count <= 4'h0;
    end else begin
      if (wr_en) begin
        wr_ptr <= wr_ptr + 3'h1;
      end
      if (rd_en) begin
        rd_ptr <= rd_ptr + 3'h1;
      end
      fifo_count <= fifo_count + {3'h0, wr_en} - {3'h0, rd_en};
    end
  end

  // storage has no reset, so it can map onto plain ram
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      fifo_mem[wr_ptr] <= {wr_chan, wr_val};
    end
  end

  // only the popped entry reaches the data port
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_data <= 16'h0000;
    end else if (rd_en) begin
      fifo_data <= fifo_mem[rd_ptr];
    end
  end

  // sticky flags: set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_flag <= 8'h00;
      batt_flag <= 2'h0;
      seq_flag <= 2'h0;
    end else begin
      mon_flag <= (mon_flag & ~mon_clear) | mon_hit;
      batt_flag <= (batt_flag & ~batt_clear) | batt_hit;
      seq_flag <= (seq_flag & ~seq_clear) | scan_end;
    end
  end

  // registered so the interrupt line cannot glitch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_enable & irq_src);
    end
  end
endmodule : das_sequencer

// *** das_sequencer_monitor.sv ***
// port-level checks for the scan sequencer
`timescale 1ns/100ps
module das_sequencer_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] mux_sel [das_pkg::NUM_CONV],
  input wire logic [1:0] conv_start,
  input wire logic fifo_read,
  input wire logic [15:0] fifo_data,
  input wire logic [3:0] fifo_count,
  input wire logic [7:0] mon_flag,
  input wire logic [7:0] mon_clear,
  input wire logic [2:0] irq_enable,
  input wire logic irq,
  input wire logic [1:0] busy,
  input wire logic warm
);
  // slack of a few cycles for the mux update latency
  localparam int MIN_DWELL = das_pkg::SAMPLE_CYC - 4;
  logic [3:0] prev_sel;
  int dwell;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_sel <= 4'h0;
      dwell <= 0;
    end else begin
      prev_sel <= mux_sel[0];
      dwell <= (mux_sel[0] != prev_sel) ? 0 : dwell + 1;
    end
  end
  chk_sample_time: assert property (conv_start[0] |-> dwell >= MIN_DWELL)
    else $error("conversion started before sample time");
  chk_start_pulse: assert property (conv_start[0] |=> !conv_start[0])
    else $error("conversion start longer than one cycle");
  chk_batt_first: assert property (mux_sel[1] != das_pkg::BATT_CHAN)
    else $error("second converter selected battery");
  chk_fifo_depth: assert property (fifo_count <= 4'h8)
    else $error("fifo count above depth");
  chk_tag_range: assert property (fifo_data[15:12] <= das_pkg::BATT_CHAN)
    else $error("fifo tag out of range");
  chk_pop_count: assert property (fifo_read && fifo_count != 4'h0
    |=> fifo_count <= $past(fifo_count))
    else $error("fifo pop did not lower count");
  chk_empty_read: assert property (fifo_read && fifo_count == 4'h0
    |=> $stable(fifo_data))
    else $error("empty read changed data");
  chk_flag_sticky: assert property (mon_flag[0] && !mon_clear[0] |=> mon_flag[0])
    else $error("monitor flag dropped without clear");
  chk_irq_masked: assert property (irq_enable == 3'h0 [*2] |-> !irq)
    else $error("interrupt raised while all masked");
  chk_scan_warm: assert property (busy != 2'h0 |-> warm)
    else $error("scan ran before warm-up");
endmodule : das_sequencer_monitor
bind das_sequencer das_sequencer_monitor i_mon (.sys_clk, .rst_n, .mux_sel,
  .conv_start, .fifo_read, .fifo_data, .fifo_count, .mon_flag, .mon_clear,
  .irq_enable, .irq, .busy, .warm);

// *** das_core_model.sv ***
// behavioural model of the two analog converter cores
`timescale 1ns/100ps
module das_core_model #(parameter int LAT0 = 3, parameter int LAT1 = 9) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] conv_start,
  input wire logic [3:0] mux_sel [2],
  input wire logic [11:0] chan_val [9],
  output logic [1:0] conv_done,
  output logic [11:0] conv_result [2]
);
  for (genvar i = 0; i < 2; i++) begin : g_core
    int cnt;
    logic done_r;
    logic [11:0] held;
    assign conv_done[i] = done_r;
    // result line shows garbage outside the done cycle
    assign conv_result[i] = done_r ? held : ~held;
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt <= 0;
        done_r <= 1'b0;
        held <= 12'h000;
      end else if (conv_start[i]) begin
        cnt <= (i == 0) ? LAT0 : LAT1;
        held <= chan_val[mux_sel[i]];
      end else begin
        cnt <= (cnt > 0) ? cnt - 1 : 0;
        done_r <= (cnt == 1);
      end
    end
  end
endmodule : das_core_model

// *** testbench.sv ***
// self-checking bench for the scan sequencer
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 1'b0, rst_n = 1'b0, fifo_read = 1'b0, rd_d = 1'b0;
  logic [7:0] prescale = 8'h01, conv_div = 8'h01, mon_clear = 8'h00;
  das_pkg::das_conv_cfg_type conv_cfg [das_pkg::NUM_CONV];
  das_pkg::das_mon_type mon_cfg [das_pkg::NUM_MON];
  logic [1:0] cmd_sample = 2'h0, batt_clear = 2'h0, seq_clear = 2'h0;
  logic [11:0] batt_high = 12'h000, batt_low = 12'h000;
  logic [3:0] fifo_level = 4'h8;
  logic [2:0] irq_enable = 3'h0;
  logic [11:0] chan_val [9];
  logic [1:0] conv_start, conv_done, batt_flag, seq_flag, busy;
  logic [11:0] conv_result [das_pkg::NUM_CONV];
  logic [3:0] mux_sel [das_pkg::NUM_CONV];
  logic [3:0] fifo_count;
  logic [3:0] ord [5] = '{4'h0, 4'h6, 4'h2, 4'h7, 4'h8};
  logic [15:0] fifo_data;
  logic [7:0] mon_flag;
  logic conv_clk, analog_on, warm, irq, clk_seen;
  logic [15:0] exp_q [$];
  int failures = 0, n_compared = 0, cyc = 0;
  das_sequencer i_dut (.sys_clk, .rst_n, .prescale, .conv_div, .conv_cfg,
    .cmd_sample, .mon_cfg, .batt_high, .batt_low, .conv_done, .conv_result,
    .fifo_read, .fifo_level, .irq_enable, .mon_clear, .batt_clear, .seq_clear,
    .mux_sel, .conv_start, .conv_clk, .analog_on, .warm, .fifo_data,
    .fifo_count, .mon_flag, .batt_flag, .seq_flag, .busy, .irq);
  das_core_model i_core (.sys_clk, .rst_n, .conv_start, .mux_sel, .chan_val,
    .conv_done, .conv_result);
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tk(int n);
    repeat (n) @(posedge sys_clk);
  endtask : tk
  task automatic summarize;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rd_d) chk("fifo_data", exp_q.pop_front(), fifo_data);
    rd_d <= fifo_read && fifo_count != 4'h0;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    conv_cfg = '{default: '0};
    mon_cfg = '{default: '0};
    void'($urandom(32'he2b275a0));
    // strict compares need room on both sides of each value
    for (int i = 0; i < 9; i++) chan_val[i] = 12'h001 + 12'($urandom % 4093);
    tk(20);
    rst_n <= 1'b1;
    prescale <= 8'($urandom_range(255, 1));
    conv_div <= 8'($urandom_range(255, 1));
    conv_cfg[0] <= '{1'b1, 9'h105, 32'hffffffff};
    conv_cfg[1] <= '{1'b1, 9'h1c0, 32'hffffffff};
    mon_cfg[0] <= '{1'b1, 1'b1, 4'h2, chan_val[2] - 12'h001};
    mon_cfg[1] <= '{1'b1, 1'b0, 4'h2, chan_val[2] + 12'h001};
    mon_cfg[2] <= '{1'b1, 1'b1, 4'h7, 12'hfff};
    batt_high <= chan_val[8] - 12'h001;
    irq_enable <= 3'h1;
    for (int i = 0; i < 500 && warm !== 1'b1; i++) tk(1);
    chk("warm", 1'b1, warm);
    chk("analog_on", 1'b1, analog_on);
    clk_seen = conv_clk;
    tk(int'(conv_div));
    chk("conv_clk", {15'h0000, ~clk_seen}, {15'h0000, conv_clk});
    cmd_sample <= 2'h3;
    tk(1);
    cmd_sample <= 2'h0;
    tk(2);
    chk("busy", 2'h3, busy);
    for (int i = 0; i < 5000 && busy !== 2'h0; i++) tk(1);
    tk(4);
    chk("fifo_count", 4'h5, fifo_count);
    chk("seq_flag", 2'h3, seq_flag);
    chk("mon_flag", 8'h03, mon_flag);
    chk("batt_flag", 2'h2, batt_flag);
    chk("irq", 1'b1, irq);
    foreach (ord[k]) begin
      exp_q.push_back({ord[k], chan_val[ord[k]]});
      fifo_read <= 1'b1;
      tk(1);
      fifo_read <= 1'b0;
      tk(1);
    end
    fifo_read <= 1'b1;
    tk(1);
    fifo_read <= 1'b0;
    irq_enable <= 3'h0;
    {mon_clear, batt_clear, seq_clear} <= 12'hfff;
    tk(1);
    {mon_clear, batt_clear, seq_clear} <= 12'h000;
    tk(3);
    chk("fifo_empty", 4'h0, fifo_count);
    chk("cleared", 12'h000, {mon_flag, batt_flag, seq_flag});
    chk("irq_off", 1'b0, irq);
    summarize();
  end
endmodule : testbench
